// File: pkg/scrp_pkg.sv
// Shared constants for the serial control register port and its controller.
// Operation
// - Controller drives clock and framing to all devices.
// - Device repeats upstream to downstream, reads reversed.
// - Transactions use 16-bit packets, cycles 0-15.
// - Data sampled on falling edge; framing both edges.
// - Pattern 11110000 on framing line starts request.
// - Request: reserved, select, opcode, broadcast, select.
// - Device acts only when select matches identity or the broadcast flag is set.
// - Broadcast flag selects every device.
// - Address packet: 12 bits in cycles 4-15.
// - Write: request, address, data, zero interval.
// - Read: request, address, interval, returned data.
// - Device launches read data on falling edge.
// - Data packet carries bit 15 first.
// - Opcodes: read 0000, write 0001, no-op 1111.
// - Reset-set: set reset bit, registers to defaults.
// - Reset-clear clears bit; wait four clock periods.
// - Fast-clock enters fast mode; wait four periods.
// - Reset and fast commands are request packet only.
// - Reset-set and reset-clear always issued as pair.
// - Pair gap: max of 16 serial, 2816 channel periods.
// - Controller drives reserved bits as zero.
// - Port reset first, serial clock low until then.
package scrp_pkg;
  localparam int PKT_BITS = 16;
  localparam logic [7:0] FRAME_PAT = 8'hF0;
  localparam logic [3:0] OP_READ = 4'h0;
  localparam logic [3:0] OP_WRITE = 4'h1;
  localparam logic [3:0] OP_RST_SET = 4'h2;
  localparam logic [3:0] OP_FAST = 4'h4;
  localparam logic [3:0] OP_RST_CLR = 4'hB;
  localparam logic [3:0] OP_NOP = 4'hF;
  // Positions inside a received 16-bit word; cycle c lands at bit 15-c.
  localparam int OP_LSB = 6;
  localparam int BC_POS = 5;
  localparam int DEV_TOP_POS = 10;
  localparam int DEV_LO_MSB = 4;
  localparam int ADDR_BITS = 12;
  // Device register file.
  localparam int NREG = 8;
  localparam int REG_IDX_BITS = 3;
  localparam logic [2:0] INIT_IDX = 3'h1;
  localparam int ID_MSB = 5;
  localparam logic [15:0] INIT_RST = 16'h00BF;
  // Timing.
  localparam int PCLK_NS = 40;
  localparam int SCK_NS = 320;
  localparam int SCK_DIV = SCK_NS / PCLK_NS;
  localparam int CHAN_CYCLE_NS = 2;
  localparam int POST_CMD_SCK = 4;
  localparam int PAIR_GAP_MIN_SCK = 16;
  localparam int PAIR_GAP_CHAN = 2816;
  localparam int PAIR_GAP_CH_SCK = (PAIR_GAP_CHAN * CHAN_CYCLE_NS + SCK_NS - 1) / SCK_NS;
  localparam int PAIR_GAP_SCK = (PAIR_GAP_CH_SCK > PAIR_GAP_MIN_SCK) ?
                                PAIR_GAP_CH_SCK : PAIR_GAP_MIN_SCK;
  // Controller APB map.
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_ADDR = 8'h04;
  localparam logic [7:0] A_WDATA = 8'h08;
  localparam logic [7:0] A_STATUS = 8'h0C;
  localparam logic [7:0] A_CTRL = 8'h10;
  localparam int CMD_BC_POS = 4;
  localparam int CMD_DEV_LSB = 8;
  localparam int ST_RDATA_LSB = 16;
endpackage

// File: pkg/scrp_if.sv
// Serial control bus between the controller and the first device of the chain.
`timescale 1ns/100ps
interface scrp_if;
  logic sck;
  logic cmd;
  logic port_rst;
  logic ctl_sio_o;
  logic ctl_sio_oe;
  logic dev_sio_o;
  logic dev_sio_oe;
  logic sio;
  // Undriven line reads low.
  assign sio = ctl_sio_oe ? ctl_sio_o : (dev_sio_oe ? dev_sio_o : 1'b0);
  modport ctl (output sck, output cmd, output port_rst, output ctl_sio_o,
               output ctl_sio_oe, input sio);
  modport dev (input sck, input cmd, input port_rst, output dev_sio_o,
               output dev_sio_oe, input sio);
endinterface

// File: rtl/scrp_dev.sv
// Device end: serial control register port with daisy-chain repeater.
`timescale 1ns/100ps
module scrp_dev (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Serial bus, upstream side
  scrp_if.dev bus,
  // Downstream serial data pin
  input wire logic sio_dn_i,
  output logic sio_dn_o,
  output logic sio_dn_oe,
  // Device state
  output logic reset_bit,
  output logic fast_mode,
  output logic [5:0] serial_identity
);
  typedef enum logic [2:0] {D_IDLE, D_REQ, D_ADDR, D_DATA, D_INTV, D_RDOUT} scrp_dst_t;
  localparam int ADDR_W = scrp_pkg::ADDR_BITS;

  logic [1:0] sck_q, cmd_q, up_q, dn_q, prst_q;
  logic sck_d;
  logic fall, rise;
  logic [7:0] frm_r;
  logic armed_r;
  scrp_dst_t state_r;
  logic [3:0] bitcnt_r;
  logic [4:0] rdcnt_r;
  logic [15:0] sr_r;
  logic [15:0] word;
  logic done;
  logic [3:0] op_r;
  logic sel_r;
  logic [ADDR_W-1:0] addr_r;
  logic [15:0] rd_sr_r;
  logic [15:0] regs_r [scrp_pkg::NREG];
  logic [5:0] dev_sel;
  logic hit;
  logic [15:0] rd_val;

  // Every outside signal passes two flops before any logic reads it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q <= 2'h0;
      cmd_q <= 2'h0;
      up_q <= 2'h0;
      dn_q <= 2'h0;
      prst_q <= 2'h3;
      sck_d <= 1'b0;
    end else begin
      sck_q <= {sck_q[0], bus.sck};
      cmd_q <= {cmd_q[0], bus.cmd};
      up_q <= {up_q[0], bus.sio};
      dn_q <= {dn_q[0], sio_dn_i};
      prst_q <= {prst_q[0], bus.port_rst};
      sck_d <= sck_q[1];
    end
  end

  assign fall = sck_d & ~sck_q[1];
  assign rise = ~sck_d & sck_q[1];
  assign word = {sr_r[14:0], up_q[1]};
  assign done = fall && (bitcnt_r == 4'hF);
  assign dev_sel = {word[scrp_pkg::DEV_TOP_POS], word[scrp_pkg::DEV_LO_MSB:0]};
  assign serial_identity = regs_r[scrp_pkg::INIT_IDX][scrp_pkg::ID_MSB:0];
  assign hit = (addr_r[ADDR_W-1:scrp_pkg::REG_IDX_BITS] == '0);
  assign rd_val = hit ? regs_r[addr_r[scrp_pkg::REG_IDX_BITS-1:0]] : 16'h0000;

  // Framing is sampled on both clock edges; the match arms the next falling edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frm_r <= 8'h00;
      armed_r <= 1'b0;
    end else if (prst_q[1]) begin
      frm_r <= 8'h00;
      armed_r <= 1'b0;
    end else begin
      if (rise || fall) begin
        frm_r <= {frm_r[6:0], cmd_q[1]};
      end
      if (rise && ({frm_r[6:0], cmd_q[1]} == scrp_pkg::FRAME_PAT)) begin
        armed_r <= 1'b1;
      end else if (fall) begin
        armed_r <= 1'b0;
      end
    end
  end

  // Packet sequencer, advanced only on falling serial clock edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= D_IDLE;
      bitcnt_r <= 4'h0;
      rdcnt_r <= 5'h00;
      sr_r <= 16'h0000;
      op_r <= 4'h0;
      sel_r <= 1'b0;
      addr_r <= '0;
    end else if (prst_q[1]) begin
      state_r <= D_IDLE;
      bitcnt_r <= 4'h0;
      rdcnt_r <= 5'h00;
    end else if (fall) begin
      sr_r <= word;
      bitcnt_r <= bitcnt_r + 4'h1;
      unique case (state_r)
        D_IDLE: begin
          bitcnt_r <= 4'h1;
          if (armed_r) begin
            state_r <= D_REQ;
          end
        end
        D_REQ: begin
          if (done) begin
            op_r <= word[scrp_pkg::OP_LSB+3:scrp_pkg::OP_LSB];
            sel_r <= word[scrp_pkg::BC_POS] ||
                     (dev_sel == serial_identity);
            if (word[scrp_pkg::OP_LSB+3:scrp_pkg::OP_LSB] == scrp_pkg::OP_READ ||
                word[scrp_pkg::OP_LSB+3:scrp_pkg::OP_LSB] == scrp_pkg::OP_WRITE) begin
              state_r <= D_ADDR;
            end else begin
              state_r <= D_IDLE;
            end
          end
        end
        D_ADDR: begin
          if (done) begin
            addr_r <= word[ADDR_W-1:0];
            state_r <= (op_r == scrp_pkg::OP_WRITE) ? D_DATA : D_INTV;
          end
        end
        D_DATA: begin
          if (done) begin
            state_r <= D_INTV;
          end
        end
        D_INTV: begin
          if (done) begin
            rdcnt_r <= 5'h00;
            state_r <= (op_r == scrp_pkg::OP_READ) ? D_RDOUT : D_IDLE;
          end
        end
        D_RDOUT: begin
          // One extra edge keeps the last bit on the line for a full period.
          rdcnt_r <= rdcnt_r + 5'h01;
          if (rdcnt_r == 5'h10) begin
            state_r <= D_IDLE;
          end
        end
      endcase
    end
  end

  // Register file and the effects of the control commands.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < scrp_pkg::NREG; i++) begin
        regs_r[i] <= (i == scrp_pkg::INIT_IDX) ? scrp_pkg::INIT_RST : 16'h0000;
      end
      reset_bit <= 1'b0;
      fast_mode <= 1'b0;
    end else if (prst_q[1]) begin
      for (int i = 0; i < scrp_pkg::NREG; i++) begin
        regs_r[i] <= (i == scrp_pkg::INIT_IDX) ? scrp_pkg::INIT_RST : 16'h0000;
      end
      fast_mode <= 1'b0;
    end else if (done && state_r == D_REQ &&
                 (word[scrp_pkg::BC_POS] || dev_sel == serial_identity)) begin
      unique case (word[scrp_pkg::OP_LSB+3:scrp_pkg::OP_LSB])
        scrp_pkg::OP_RST_SET: begin
          reset_bit <= 1'b1;
          for (int i = 0; i < scrp_pkg::NREG; i++) begin
            regs_r[i] <= (i == scrp_pkg::INIT_IDX) ? scrp_pkg::INIT_RST : 16'h0000;
          end
        end
        scrp_pkg::OP_RST_CLR: reset_bit <= 1'b0;
        scrp_pkg::OP_FAST: fast_mode <= 1'b1;
        default: begin
        end
      endcase
    end else if (done && state_r == D_DATA && sel_r && hit) begin
      // Stored as the interval begins so side effects settle within it.
      regs_r[addr_r[scrp_pkg::REG_IDX_BITS-1:0]] <= word;
    end
  end

  // Pin drivers: repeat downstream, turn around for returned read data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sio_dn_o <= 1'b0;
      sio_dn_oe <= 1'b1;
      bus.dev_sio_o <= 1'b0;
      bus.dev_sio_oe <= 1'b0;
      rd_sr_r <= 16'h0000;
    end else if (state_r == D_RDOUT && !prst_q[1]) begin
      sio_dn_oe <= 1'b0;
      bus.dev_sio_oe <= 1'b1;
      if (!sel_r) begin
        bus.dev_sio_o <= dn_q[1];
      end else if (fall) begin
        bus.dev_sio_o <= rd_sr_r[15];
        rd_sr_r <= {rd_sr_r[14:0], 1'b0};
      end
    end else begin
      sio_dn_oe <= 1'b1;
      sio_dn_o <= up_q[1];
      bus.dev_sio_oe <= 1'b0;
      bus.dev_sio_o <= 1'b0;
      if (done && state_r == D_INTV) begin
        rd_sr_r <= rd_val;
      end
    end
  end
endmodule

// File: rtl/scrp_ctl.sv
// Controller end: APB-programmed master of the serial control bus.
`timescale 1ns/100ps
module scrp_ctl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial bus
  scrp_if.ctl bus
);
  typedef enum logic [2:0] {C_IDLE, C_FRAME, C_SHIFT, C_RDCAP, C_TAIL} scrp_cst_t;

  scrp_cst_t state_r;
  logic [2:0] ph_r;
  logic [2:0] fcnt_r;
  logic [6:0] nbits_r;
  logic [4:0] rcnt_r;
  logic [7:0] tail_r;
  logic [63:0] tx_r;
  logic [15:0] rdata_r;
  logic [31:0] cmd_r;
  logic [11:0] addr_r;
  logic [15:0] wdata_r;
  logic pend_set_r;
  logic is_rd_r;
  logic [1:0] sio_q;
  logic setup;
  logic access;
  logic cmd_ok;
  logic [3:0] op;
  logic bad_op;
  logic start;
  logic [15:0] req;

  assign setup = psel && !penable;
  // Writes land only at the access edge that sees pready high, never at setup.
  assign access = psel && penable && pready;
  assign op = pwdata[3:0];
  // Unlisted opcodes and any break of the reset pairing are refused.
  assign bad_op = !(op == scrp_pkg::OP_READ || op == scrp_pkg::OP_WRITE ||
                    op == scrp_pkg::OP_RST_SET || op == scrp_pkg::OP_RST_CLR ||
                    op == scrp_pkg::OP_FAST || op == scrp_pkg::OP_NOP) ||
                  (pend_set_r != (op == scrp_pkg::OP_RST_CLR));
  assign cmd_ok = state_r == C_IDLE && !bad_op && !bus.port_rst;
  assign start = access && pwrite && paddr == scrp_pkg::A_CMD && cmd_ok;
  assign req = {5'h00, pwdata[scrp_pkg::CMD_DEV_LSB+5], op, pwdata[scrp_pkg::CMD_BC_POS],
                pwdata[scrp_pkg::CMD_DEV_LSB+4:scrp_pkg::CMD_DEV_LSB]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sio_q <= 2'h0;
    end else begin
      sio_q <= {sio_q[0], bus.sio};
    end
  end

  // APB slave: answer prepared in the setup cycle, ready raised for the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      cmd_r <= 32'h00000000;
      addr_r <= 12'h000;
      wdata_r <= 16'h0000;
      bus.port_rst <= 1'b1;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
        unique case (paddr)
          scrp_pkg::A_CMD: begin
            if (pwrite && !cmd_ok) begin
              pslverr <= 1'b1;
            end
            prdata <= cmd_r;
          end
          scrp_pkg::A_ADDR: begin
            prdata <= {20'h00000, addr_r};
          end
          scrp_pkg::A_WDATA: begin
            prdata <= {16'h0000, wdata_r};
          end
          scrp_pkg::A_STATUS: begin
            prdata <= {rdata_r, 13'h0000, bus.port_rst, pend_set_r, state_r != C_IDLE};
          end
          scrp_pkg::A_CTRL: begin
            prdata <= {31'h00000000, bus.port_rst};
          end
          default: pslverr <= 1'b1;
        endcase
      end
      if (access && pwrite) begin
        unique case (paddr)
          scrp_pkg::A_CMD: begin
            if (start) begin
              cmd_r <= pwdata;
            end
          end
          scrp_pkg::A_ADDR: begin
            addr_r <= pwdata[11:0];
          end
          scrp_pkg::A_WDATA: begin
            wdata_r <= pwdata[15:0];
          end
          scrp_pkg::A_CTRL: begin
            bus.port_rst <= pwdata[0] && state_r == C_IDLE;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Serial sequencer; one serial clock period is SCK_DIV pclk cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= C_IDLE;
      ph_r <= 3'h0;
      fcnt_r <= 3'h0;
      nbits_r <= 7'h00;
      rcnt_r <= 5'h00;
      tail_r <= 8'h00;
      tx_r <= 64'h0;
      rdata_r <= 16'h0000;
      pend_set_r <= 1'b0;
      is_rd_r <= 1'b0;
      bus.sck <= 1'b0;
      bus.cmd <= 1'b0;
      bus.ctl_sio_o <= 1'b0;
      bus.ctl_sio_oe <= 1'b1;
    end else begin
      // Phase restarts at zero on start so the first high half is a full one.
      ph_r <= (state_r == C_IDLE) ? 3'h0 : ph_r + 3'h1;
      // Clock held low while idle; high for the first half of each period.
      bus.sck <= (state_r != C_IDLE) && !ph_r[2];
      unique case (state_r)
        C_IDLE: begin
          bus.ctl_sio_oe <= 1'b1;
          bus.ctl_sio_o <= 1'b0;
          if (start) begin
            state_r <= C_FRAME;
            fcnt_r <= 3'h0;
            is_rd_r <= (op == scrp_pkg::OP_READ);
            pend_set_r <= (op == scrp_pkg::OP_RST_SET);
            tx_r <= {req, 4'h0, addr_r, (op == scrp_pkg::OP_WRITE) ? wdata_r : 16'h0000,
                     16'h0000};
            nbits_r <= (op == scrp_pkg::OP_WRITE) ? 7'h40 :
                       (op == scrp_pkg::OP_READ) ? 7'h30 : 7'h10;
            tail_r <= (op == scrp_pkg::OP_RST_SET) ? 8'(scrp_pkg::PAIR_GAP_SCK) :
                      (op == scrp_pkg::OP_RST_CLR || op == scrp_pkg::OP_FAST) ?
                      8'(scrp_pkg::POST_CMD_SCK) : 8'h01;
          end
        end
        C_FRAME: begin
          // Each framing bit is set mid-half so either edge samples it cleanly.
          if (ph_r == 3'h2 || ph_r == 3'h6) begin
            bus.cmd <= !fcnt_r[2];
            fcnt_r <= fcnt_r + 3'h1;
          end
          if (ph_r == 3'h7 && fcnt_r == 3'h0) begin
            state_r <= C_SHIFT;
          end
        end
        C_SHIFT: begin
          if (ph_r == 3'h0) begin
            bus.ctl_sio_o <= tx_r[63];
            tx_r <= {tx_r[62:0], 1'b0};
          end
          if (ph_r == 3'h7) begin
            nbits_r <= nbits_r - 7'h01;
            if (nbits_r == 7'h01) begin
              rcnt_r <= 5'h00;
              state_r <= is_rd_r ? C_RDCAP : C_TAIL;
              bus.ctl_sio_oe <= !is_rd_r;
              bus.ctl_sio_o <= 1'b0;
            end
          end
        end
        C_RDCAP: begin
          // Returned bit k is taken at the fall ending its cycle, half a period late.
          if (ph_r == 3'h4) begin
            rcnt_r <= rcnt_r + 5'h01;
            if (rcnt_r != 5'h00) begin
              rdata_r <= {rdata_r[14:0], sio_q[1]};
            end
          end
          if (ph_r == 3'h7 && rcnt_r == 5'h11) begin
            state_r <= C_TAIL;
            bus.ctl_sio_oe <= 1'b1;
          end
        end
        C_TAIL: begin
          if (ph_r == 3'h7) begin
            tail_r <= tail_r - 8'h01;
            if (tail_r == 8'h01) begin
              state_r <= C_IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule

// File: verification/scrp_asserts.sv
// Concurrent checks on the serial bus between the controller and the device.
`timescale 1ns/100ps
module scrp_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Serial bus
  input wire logic sck,
  input wire logic cmd,
  input wire logic port_rst,
  input wire logic ctl_sio_o,
  input wire logic ctl_sio_oe,
  input wire logic dev_sio_o,
  input wire logic dev_sio_oe,
  input wire logic sio
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Four framing ones take four half periods of four cycles each, then four zeros.
  sequence frame_ones_s;
    cmd [*8] ##8 cmd;
  endsequence
  sequence frame_zeros_s;
    !cmd [*8] ##8 !cmd;
  endsequence
  sequence sck_high_s;
    sck [*4] ##1 !sck;
  endsequence

  frame_pattern_a: assert property ($rose(cmd) |-> frame_ones_s ##1 frame_zeros_s)
    else $error("framing pattern on the command line is wrong");
  frame_edge_a: assert property ($rose(cmd) |-> ##[1:8] $fell(sck))
    else $error("framing not aligned to a serial clock fall");
  sck_high_a: assert property ($rose(sck) |-> sck_high_s)
    else $error("serial clock high phase has the wrong length");
  sck_low_a: assert property ($fell(sck) |-> !sck [*4])
    else $error("serial clock low phase too short");
  idle_clock_a: assert property (port_rst |-> !sck)
    else $error("serial clock runs during port reset");
  ctl_bit_stable_a: assert property (ctl_sio_oe && $fell(sck) |-> $stable(ctl_sio_o) ##1 $stable(ctl_sio_o))
    else $error("controller data moves at the sampling fall");
  read_launch_a: assert property (dev_sio_oe && !ctl_sio_oe && $fell(sck) |-> $stable(sio))
    else $error("returned data moves at the sampling fall");
  read_handover_a: assert property ($fell(ctl_sio_oe) |-> ##1 dev_sio_oe && sio == dev_sio_o)
    else $error("no device drives the line after the controller lets go");
  line_return_a: assert property ($fell(dev_sio_oe) |-> ##[1:8] ctl_sio_oe)
    else $error("controller does not take the line back");
endmodule

// File: verification/serial_control_register_port_tb.sv
// Bench joining the controller and one device over the serial bus.
`timescale 1ns/100ps
module serial_control_register_port_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, up_q, dn_q;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic sio_dn_i, sio_dn_o, sio_dn_oe, reset_bit, fast_mode;
  logic [5:0] serial_identity;
  int mismatches, checks_done, cycles, up_rises, dn_rises, u0, d0;
  scrp_if bus ();
  scrp_ctl u_scrp_ctl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(bus.ctl));
  scrp_dev u_scrp_dev (.pclk(pclk), .presetn(presetn), .bus(bus.dev), .sio_dn_i(sio_dn_i),
    .sio_dn_o(sio_dn_o), .sio_dn_oe(sio_dn_oe), .reset_bit(reset_bit), .fast_mode(fast_mode),
    .serial_identity(serial_identity));
  scrp_asserts u_scrp_asserts (.pclk(pclk), .presetn(presetn), .sck(bus.sck), .cmd(bus.cmd),
    .port_rst(bus.port_rst), .ctl_sio_o(bus.ctl_sio_o), .ctl_sio_oe(bus.ctl_sio_oe),
    .dev_sio_o(bus.dev_sio_o), .dev_sio_oe(bus.dev_sio_oe), .sio(bus.sio));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Rising edges are counted rather than bits, so the repeat delay does not matter.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    up_q <= bus.sio;
    dn_q <= sio_dn_o;
    if (bus.ctl_sio_oe && bus.sio && !up_q) up_rises <= up_rises + 1;
    if (sio_dn_oe && sio_dn_o && !dn_q) dn_rises <= dn_rises + 1;
    if (cycles == 40000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // A refused command starts nothing, so only accepted ones are waited for.
  task automatic op(input logic [3:0] o, input logic bc, input logic [5:0] dv, input logic e);
    logic [31:0] w;
    w = 32'h0;
    w[3:0] = o;
    w[scrp_pkg::CMD_BC_POS] = bc;
    w[13:8] = dv;
    apb(1'b1, scrp_pkg::A_CMD, w);
    check("command refusal", 32'(err), 32'(e));
    if (!e) begin
      do apb(1'b0, scrp_pkg::A_STATUS, 32'h0); while (rd[0] !== 1'b0);
    end
  endtask

  task automatic wrreg(input logic [5:0] dv, input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, scrp_pkg::A_ADDR, 32'(a));
    apb(1'b1, scrp_pkg::A_WDATA, 32'(d));
    op(scrp_pkg::OP_WRITE, 1'b0, dv, 1'b0);
  endtask

  task automatic rdreg(input logic bc, input logic [5:0] dv, input logic [11:0] a,
                       input logic [15:0] exp);
    apb(1'b1, scrp_pkg::A_ADDR, 32'(a));
    op(scrp_pkg::OP_READ, bc, dv, 1'b0);
    check("read data", 32'(rd[31:16]), 32'(exp));
  endtask

  task automatic t_reset();
    check("serial clock", 32'(bus.sck), 32'h0);
    check("identity", 32'(serial_identity), 32'h3F);
    check("reset bit", 32'(reset_bit), 32'h0);
    check("fast mode", 32'(fast_mode), 32'h0);
    apb(1'b0, scrp_pkg::A_STATUS, 32'h0);
    check("port reset status", 32'(rd[2]), 32'h1);
    op(scrp_pkg::OP_NOP, 1'b1, 6'h00, 1'b1);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped error", 32'(err), 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, scrp_pkg::A_CTRL, 32'h0);
    @(posedge pclk);
    check("port reset line", 32'(bus.port_rst), 32'h0);
  endtask

  task automatic t_write_read();
    u0 = up_rises;
    d0 = dn_rises;
    wrreg(6'h3F, 12'h002, 16'hA5C3);
    check("repeated edges", 32'(dn_rises - d0), 32'(up_rises - u0));
    rdreg(1'b0, 6'h3F, 12'h002, 16'hA5C3);
    rdreg(1'b0, 6'h3F, 12'h100, 16'h0000);
  endtask

  task automatic t_select();
    sio_dn_i <= 1'b1;
    rdreg(1'b0, 6'h01, 12'h002, 16'hFFFF);
    sio_dn_i <= 1'b0;
    wrreg(6'h01, 12'h002, 16'h0000);
    rdreg(1'b1, 6'h01, 12'h002, 16'hA5C3);
    wrreg(6'h3F, 12'h001, 16'h0085);
    check("identity", 32'(serial_identity), 32'h05);
    rdreg(1'b0, 6'h05, 12'h002, 16'hA5C3);
  endtask

  task automatic t_ops();
    op(scrp_pkg::OP_FAST, 1'b1, 6'h00, 1'b0);
    check("fast mode", 32'(fast_mode), 32'h1);
    op(4'h3, 1'b1, 6'h00, 1'b1);
    op(scrp_pkg::OP_NOP, 1'b1, 6'h00, 1'b0);
    u0 = cycles;
    op(scrp_pkg::OP_RST_SET, 1'b1, 6'h00, 1'b0);
    check("pair gap", 32'(cycles - u0 > scrp_pkg::PAIR_GAP_SCK * scrp_pkg::SCK_DIV), 32'h1);
    check("reset bit", 32'(reset_bit), 32'h1);
    check("identity", 32'(serial_identity), 32'h3F);
    op(scrp_pkg::OP_NOP, 1'b1, 6'h00, 1'b1);
    op(scrp_pkg::OP_RST_CLR, 1'b1, 6'h00, 1'b0);
    check("reset bit", 32'(reset_bit), 32'h0);
    rdreg(1'b0, 6'h3F, 12'h002, 16'h0000);
  endtask

  task automatic complete_run();
    $display("Mismatches %0d, checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, sio_dn_i} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_write_read();
    t_select();
    t_ops();
    complete_run();
  end
endmodule
